// ===== inc/async_sysctl_pkg.sv
package async_sysctl_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [11:0] OFS_RESET_CTRL      = 12'h000;
	localparam logic [11:0] OFS_RESET_SET       = 12'h004;
	localparam logic [11:0] OFS_RESET_CLR       = 12'h008;
	localparam logic [11:0] OFS_GATE_CTRL       = 12'h010;
	localparam logic [11:0] OFS_GATE_SET        = 12'h014;
	localparam logic [11:0] OFS_GATE_CLR        = 12'h018;
	localparam logic [11:0] OFS_SRC_SEL         = 12'h020;
	localparam logic [11:0] OFS_CLK_DIV         = 12'h030;
	localparam logic [11:0] OFS_BROWNOUT        = 12'h044;
	localparam logic [11:0] OFS_IRQ_STATUS      = 12'h050;
	localparam logic [11:0] OFS_IRQ_MASK        = 12'h054;

	// Implemented bits of the reset and gate registers
	localparam int          TIMER3_BIT          = 13;
	localparam logic [31:0] RESET_CTRL_IMPL     = 32'h0000_2000;
	localparam logic [31:0] GATE_CTRL_IMPL      = 32'h0000_2000;
	localparam logic [31:0] RESET_CTRL_RST      = 32'h0000_0000;
	localparam logic [31:0] GATE_CTRL_RST       = 32'h0000_0000;

	// Source selector
	localparam int          SRC_SEL_W           = 2;
	localparam logic [1:0]  SRC_MAIN            = 2'h0;
	localparam logic [1:0]  SRC_RC_OSC          = 2'h1;
	localparam logic [1:0]  SRC_SEL_RST         = 2'h0;

	// Divider
	localparam int          DIV_W               = 8;
	localparam logic [7:0]  DIV_RST             = 8'h01;

	// Brown-out control field positions
	localparam int          BO_RST_LVL_LSB      = 0;
	localparam int          BO_RST_ENA_BIT      = 2;
	localparam int          BO_IRQ_LVL_LSB      = 3;
	localparam int          BO_IRQ_ENA_BIT      = 5;
	localparam int          BO_RST_FLAG_BIT     = 6;
	localparam int          BO_IRQ_FLAG_BIT     = 7;
	localparam logic [7:0]  BROWNOUT_RST        = 8'h00;

	// Interrupt status bits
	localparam int          IRQ_W               = 2;
	localparam int          IRQ_SWITCH_DONE     = 0;
	localparam int          IRQ_BROWNOUT        = 1;
	localparam logic [1:0]  IRQ_RST             = 2'h0;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic       sleep;
		logic       deep_sleep;
		logic [3:0] below_rst_lvl;
		logic [3:0] below_irq_lvl;
	} supply_status_t;

	typedef enum logic [1:0] {
		SEL_IDLE,
		SEL_DROP_OLD,
		SEL_PICK_NEW
	} sel_state_t;

endpackage

// ===== rtl/async_sysctl.sv
`timescale 1ns/10ps
module async_sysctl (
	input  wire logic                           sys_clk,
	input  wire logic                           rst_b,
	input  wire async_sysctl_pkg::bus_req_t     bus_req,
	output logic [31:0]                         rd_data,
	input  wire logic                           main_clk_tick,
	input  wire logic                           rc_osc_tick,
	input  wire async_sysctl_pkg::supply_status_t supply,
	output logic                                bus_clk_pulse,
	output logic                                timer3_clk_en,
	output logic                                timer3_reset,
	output logic                                brownout_reset_req,
	output logic                                brownout_irq,
	output logic                                wake_req,
	output logic                                irq
);

	////////////////////////////////////////////////////////////////////////
	// Reset release
	logic rst_meta_ff;
	logic rst_sync_ff;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	wire logic rst_n_sync = rst_sync_ff;

	////////////////////////////////////////////////////////////////////////
	// Decode
	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		hit = (a == ofs);
	endfunction
	function automatic logic [31:0] set_clr(input logic [31:0] cur, input logic [31:0] d,
		input logic [31:0] impl, input logic set);
		set_clr = set ? (cur | (d & impl)) : (cur & ~(d & impl));
	endfunction

	wire logic wr_rst_ctrl = bus_req.wr && hit(bus_req.addr, async_sysctl_pkg::OFS_RESET_CTRL);
	wire logic wr_rst_set  = bus_req.wr && hit(bus_req.addr, async_sysctl_pkg::OFS_RESET_SET);
	wire logic wr_rst_clr  = bus_req.wr && hit(bus_req.addr, async_sysctl_pkg::OFS_RESET_CLR);
	wire logic wr_gate     = bus_req.wr && hit(bus_req.addr, async_sysctl_pkg::OFS_GATE_CTRL);
	wire logic wr_gate_set = bus_req.wr && hit(bus_req.addr, async_sysctl_pkg::OFS_GATE_SET);
	wire logic wr_gate_clr = bus_req.wr && hit(bus_req.addr, async_sysctl_pkg::OFS_GATE_CLR);
	wire logic wr_src      = bus_req.wr && hit(bus_req.addr, async_sysctl_pkg::OFS_SRC_SEL);
	wire logic wr_div      = bus_req.wr && hit(bus_req.addr, async_sysctl_pkg::OFS_CLK_DIV);
	wire logic wr_bo       = bus_req.wr && hit(bus_req.addr, async_sysctl_pkg::OFS_BROWNOUT);
	wire logic wr_irq_st   = bus_req.wr && hit(bus_req.addr, async_sysctl_pkg::OFS_IRQ_STATUS);
	wire logic wr_irq_mask = bus_req.wr && hit(bus_req.addr, async_sysctl_pkg::OFS_IRQ_MASK);

	////////////////////////////////////////////////////////////////////////
	// Reset control and clock gate registers
	logic [31:0] reset_ctrl_ff;
	logic [31:0] gate_ctrl_ff;

	always_ff @(posedge sys_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			reset_ctrl_ff <= async_sysctl_pkg::RESET_CTRL_RST;
		end else if (wr_rst_ctrl) begin
			reset_ctrl_ff <= bus_req.wdata & async_sysctl_pkg::RESET_CTRL_IMPL;
		end else if (wr_rst_set) begin
			reset_ctrl_ff <= set_clr(reset_ctrl_ff, bus_req.wdata,
				async_sysctl_pkg::RESET_CTRL_IMPL, 1'b1);
		end else if (wr_rst_clr) begin
			reset_ctrl_ff <= set_clr(reset_ctrl_ff, bus_req.wdata,
				async_sysctl_pkg::RESET_CTRL_IMPL, 1'b0);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			gate_ctrl_ff <= async_sysctl_pkg::GATE_CTRL_RST;
		end else if (wr_gate) begin
			gate_ctrl_ff <= bus_req.wdata & async_sysctl_pkg::GATE_CTRL_IMPL;
		end else if (wr_gate_set) begin
			gate_ctrl_ff <= set_clr(gate_ctrl_ff, bus_req.wdata,
				async_sysctl_pkg::GATE_CTRL_IMPL, 1'b1);
		end else if (wr_gate_clr) begin
			gate_ctrl_ff <= set_clr(gate_ctrl_ff, bus_req.wdata,
				async_sysctl_pkg::GATE_CTRL_IMPL, 1'b0);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			timer3_reset <= 1'b0;
		end else begin
			timer3_reset <= reset_ctrl_ff[async_sysctl_pkg::TIMER3_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Source selector with handover
	logic [1:0]                      src_req_ff;
	logic [1:0]                      active_src_ff;
	async_sysctl_pkg::sel_state_t    sel_state_ff;

	function automatic logic src_tick(input logic [1:0] s, input logic m, input logic r);
		case (s)
			async_sysctl_pkg::SRC_MAIN:   src_tick = m;
			async_sysctl_pkg::SRC_RC_OSC: src_tick = r;
			default:                      src_tick = 1'b0;
		endcase
	endfunction
	wire logic old_tick = src_tick(active_src_ff, main_clk_tick, rc_osc_tick);
	wire logic new_tick = src_tick(src_req_ff, main_clk_tick, rc_osc_tick);
	wire logic switch_done = (sel_state_ff == async_sysctl_pkg::SEL_PICK_NEW) && new_tick;

	always_ff @(posedge sys_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			src_req_ff <= async_sysctl_pkg::SRC_SEL_RST;
		end else if (wr_src) begin
			src_req_ff <= bus_req.wdata[1:0];
		end
	end

	// A reserved code leaves the old source parked off; a stopped old clock stalls here
	always_ff @(posedge sys_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			sel_state_ff  <= async_sysctl_pkg::SEL_IDLE;
			active_src_ff <= async_sysctl_pkg::SRC_SEL_RST;
		end else begin
			case (sel_state_ff)
				async_sysctl_pkg::SEL_IDLE: begin
					if (src_req_ff != active_src_ff) begin
						sel_state_ff <= async_sysctl_pkg::SEL_DROP_OLD;
					end
				end
				async_sysctl_pkg::SEL_DROP_OLD: begin
					if (old_tick || active_src_ff[1]) begin
						sel_state_ff <= async_sysctl_pkg::SEL_PICK_NEW;
					end
				end
				async_sysctl_pkg::SEL_PICK_NEW: begin
					if (new_tick || src_req_ff[1]) begin
						active_src_ff <= src_req_ff;
						sel_state_ff  <= async_sysctl_pkg::SEL_IDLE;
					end
				end
				default: begin
					sel_state_ff <= async_sysctl_pkg::SEL_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Divider and gates
	logic [7:0] div_ff;
	logic [7:0] div_cnt_ff;
	wire logic  src_live = (sel_state_ff == async_sysctl_pkg::SEL_IDLE) && old_tick;

	always_ff @(posedge sys_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			div_ff <= async_sysctl_pkg::DIV_RST;
		end else if (wr_div) begin
			div_ff <= bus_req.wdata[7:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			div_cnt_ff    <= 8'h00;
			bus_clk_pulse <= 1'b0;
		end else if (div_ff == 8'h00) begin
			div_cnt_ff    <= 8'h00;
			bus_clk_pulse <= 1'b0;
		end else if (src_live) begin
			if (div_cnt_ff + 8'h01 >= div_ff) begin
				div_cnt_ff    <= 8'h00;
				bus_clk_pulse <= 1'b1;
			end else begin
				div_cnt_ff    <= div_cnt_ff + 8'h01;
				bus_clk_pulse <= 1'b0;
			end
		end else begin
			bus_clk_pulse <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			timer3_clk_en <= 1'b0;
		end else begin
			timer3_clk_en <= bus_clk_pulse && gate_ctrl_ff[async_sysctl_pkg::TIMER3_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Brown-out detector control
	logic [5:0]      bo_cfg_ff;
	logic [1:0]      bo_flag_ff;
	wire logic [7:0] bo_ff = {bo_flag_ff, bo_cfg_ff};
	wire logic [1:0] rst_lvl = bo_ff[async_sysctl_pkg::BO_RST_LVL_LSB +: 2];
	wire logic [1:0] irq_lvl = bo_ff[async_sysctl_pkg::BO_IRQ_LVL_LSB +: 2];
	wire logic bo_rst_hit = bo_ff[async_sysctl_pkg::BO_RST_ENA_BIT] &&
		supply.below_rst_lvl[rst_lvl];
	wire logic bo_irq_hit = bo_ff[async_sysctl_pkg::BO_IRQ_ENA_BIT] &&
		supply.below_irq_lvl[irq_lvl];
	wire logic bo_rst_w1c = wr_bo && bus_req.wdata[async_sysctl_pkg::BO_RST_FLAG_BIT];
	wire logic bo_irq_w1c = wr_bo && bus_req.wdata[async_sysctl_pkg::BO_IRQ_FLAG_BIT];

	always_ff @(posedge sys_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			bo_cfg_ff <= async_sysctl_pkg::BROWNOUT_RST[5:0];
		end else if (wr_bo) begin
			bo_cfg_ff <= bus_req.wdata[5:0];
		end
	end

	// Flags survive only if this block sits on a reset the brown-out request does not drive
	always_ff @(posedge sys_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			bo_flag_ff <= async_sysctl_pkg::BROWNOUT_RST[7:6];
		end else begin
			if (brownout_reset_req) begin
				bo_flag_ff[0] <= 1'b1;
			end else if (bo_rst_w1c) begin
				bo_flag_ff[0] <= 1'b0;
			end
			if (bo_irq_hit) begin
				bo_flag_ff[1] <= 1'b1;
			end else if (bo_irq_w1c) begin
				bo_flag_ff[1] <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			brownout_reset_req <= 1'b0;
			brownout_irq       <= 1'b0;
			wake_req           <= 1'b0;
		end else begin
			brownout_reset_req <= bo_rst_hit;
			brownout_irq       <= bo_irq_hit;
			wake_req           <= (supply.sleep || supply.deep_sleep) &&
				(bo_rst_hit || bo_irq_hit);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt status and mask
	logic [1:0] irq_st_ff;
	logic [1:0] irq_mask_ff;
	logic [1:0] nxt_irq_ev;

	always_comb begin
		nxt_irq_ev = 2'h0;
		nxt_irq_ev[async_sysctl_pkg::IRQ_SWITCH_DONE] = switch_done;
		nxt_irq_ev[async_sysctl_pkg::IRQ_BROWNOUT]    = bo_irq_hit;
	end

	// Set beats a simultaneous write-one clear
	always_ff @(posedge sys_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			irq_st_ff <= async_sysctl_pkg::IRQ_RST;
		end else begin
			irq_st_ff <= (irq_st_ff & ~(wr_irq_st ? bus_req.wdata[1:0] : 2'h0)) | nxt_irq_ev;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			irq_mask_ff <= async_sysctl_pkg::IRQ_RST;
		end else if (wr_irq_mask) begin
			irq_mask_ff <= bus_req.wdata[1:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			irq <= 1'b0;
		end else begin
			irq <= |(nxt_irq_ev & irq_mask_ff) ||
				|(irq_st_ff & ~(wr_irq_st ? bus_req.wdata[1:0] : 2'h0) & irq_mask_ff);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port
	logic [31:0] nxt_rd;

	always_comb begin
		nxt_rd = 32'h0000_0000;
		case (bus_req.addr)
			async_sysctl_pkg::OFS_RESET_CTRL: nxt_rd = reset_ctrl_ff;
			async_sysctl_pkg::OFS_GATE_CTRL:  nxt_rd = gate_ctrl_ff;
			async_sysctl_pkg::OFS_SRC_SEL:    nxt_rd = {30'h0, src_req_ff};
			async_sysctl_pkg::OFS_CLK_DIV:    nxt_rd = {24'h0, div_ff};
			async_sysctl_pkg::OFS_BROWNOUT:   nxt_rd = {24'h0, bo_ff};
			async_sysctl_pkg::OFS_IRQ_STATUS: nxt_rd = {30'h0, irq_st_ff};
			async_sysctl_pkg::OFS_IRQ_MASK:   nxt_rd = {30'h0, irq_mask_ff};
			default:                          nxt_rd = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			rd_data <= 32'h0000_0000;
		end else begin
			rd_data <= bus_req.rd ? nxt_rd : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_rst_set;
		@(posedge sys_clk) disable iff (!rst_n_sync)
		wr_rst_set |=> reset_ctrl_ff ==
			($past(reset_ctrl_ff) | ($past(bus_req.wdata) & async_sysctl_pkg::RESET_CTRL_IMPL));
	endproperty
	a_rst_set: assert property (p_rst_set) else $error("reset set alias wrong");
	property p_rst_clr;
		@(posedge sys_clk) disable iff (!rst_n_sync)
		wr_rst_clr |=> reset_ctrl_ff ==
			($past(reset_ctrl_ff) & ~($past(bus_req.wdata) & async_sysctl_pkg::RESET_CTRL_IMPL));
	endproperty
	a_rst_clr: assert property (p_rst_clr) else $error("reset clear alias wrong");
	property p_alias_reads_zero;
		@(posedge sys_clk) disable iff (!rst_n_sync)
		bus_req.rd && (hit(bus_req.addr, async_sysctl_pkg::OFS_RESET_SET) ||
			hit(bus_req.addr, async_sysctl_pkg::OFS_GATE_CLR)) |=> rd_data == 32'h0000_0000;
	endproperty
	a_alias_reads_zero: assert property (p_alias_reads_zero) else $error("alias read nonzero");
	property p_div_zero_stops;
		@(posedge sys_clk) disable iff (!rst_n_sync)
		(div_ff == 8'h00) [*2] |-> !bus_clk_pulse ##1 !timer3_clk_en;
	endproperty
	a_div_zero_stops: assert property (p_div_zero_stops) else $error("clock runs at div 0");
	property p_timer3_gate;
		@(posedge sys_clk) disable iff (!rst_n_sync)
		timer3_clk_en |-> $past(gate_ctrl_ff[async_sysctl_pkg::TIMER3_BIT]) && $past(bus_clk_pulse);
	endproperty
	a_timer3_gate: assert property (p_timer3_gate) else $error("timer3 clock ungated");
	property p_gate_set;
		@(posedge sys_clk) disable iff (!rst_n_sync)
		wr_gate_set && bus_req.wdata[async_sysctl_pkg::TIMER3_BIT]
			|=> gate_ctrl_ff[async_sysctl_pkg::TIMER3_BIT] ##0 gate_ctrl_ff[12:0] == 13'h0;
	endproperty
	a_gate_set: assert property (p_gate_set) else $error("gate set alias wrong");
	property p_gate_clr;
		@(posedge sys_clk) disable iff (!rst_n_sync)
		wr_gate_clr && bus_req.wdata[async_sysctl_pkg::TIMER3_BIT]
			|=> !gate_ctrl_ff[async_sysctl_pkg::TIMER3_BIT];
	endproperty
	a_gate_clr: assert property (p_gate_clr) else $error("gate clear alias wrong");
	property p_switch_waits;
		@(posedge sys_clk) disable iff (!rst_n_sync)
		(active_src_ff != $past(active_src_ff)) |->
			$past(sel_state_ff) == async_sysctl_pkg::SEL_PICK_NEW;
	endproperty
	a_switch_waits: assert property (p_switch_waits) else $error("source switched early");
	// Request follows the hit by one cycle, the flag by two
	property p_rst_flag;
		@(posedge sys_clk) disable iff (!rst_n_sync)
		bo_rst_hit |=> brownout_reset_req ##1 bo_ff[async_sysctl_pkg::BO_RST_FLAG_BIT];
	endproperty
	a_rst_flag: assert property (p_rst_flag) else $error("reset flag not set");
	property p_irq_flag;
		@(posedge sys_clk) disable iff (!rst_n_sync)
		bo_irq_hit |=> bo_ff[async_sysctl_pkg::BO_IRQ_FLAG_BIT] && brownout_irq;
	endproperty
	a_irq_flag: assert property (p_irq_flag) else $error("irq flag not set");
	property p_wake;
		@(posedge sys_clk) disable iff (!rst_n_sync)
		supply.deep_sleep && bo_irq_hit |=> wake_req;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on brown-out");
	c_switch: cover property (@(posedge sys_clk) disable iff (!rst_n_sync) switch_done);
	c_bo_wake: cover property (@(posedge sys_clk) disable iff (!rst_n_sync) wake_req && irq);
	c_t3: cover property (@(posedge sys_clk) disable iff (!rst_n_sync) timer3_clk_en);

endmodule

// ===== tb/tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin fail_count++; \
	$display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_top;
	logic                             sys_clk       = 1'b0;
	logic                             rst_b         = 1'b0;
	async_sysctl_pkg::bus_req_t       bus_req       = '0;
	async_sysctl_pkg::supply_status_t supply        = '0;
	logic                             main_clk_tick = 1'b0;
	logic                             rc_osc_tick   = 1'b0;
	logic [31:0]                      rd_data;
	logic                             bus_clk_pulse;
	logic                             timer3_clk_en;
	logic                             timer3_reset;
	logic                             brownout_reset_req;
	logic                             brownout_irq;
	logic                             wake_req;
	logic                             irq;
	logic [31:0]                      lfsr          = 32'h8F20_1210;
	logic                             tick_en       = 1'b0;
	logic                             rd_q          = 1'b0;
	logic [31:0]                      exp_q[$];
	logic [31:0]                      exp_v;
	logic [31:0]                      cfg;
	logic [3:0]                       oh;
	int                               fail_count    = 0;
	int                               samples_checked = 0;
	int                               pulse_cnt     = 0;
	int                               t3_cnt        = 0;
	logic [11:0]                      ra[12];
	logic [31:0]                      rv[12];
	logic [1:0]                       codes[3]      = '{2'h1, 2'h2, 2'h0};

	async_sysctl uut (
		.sys_clk            (sys_clk),
		.rst_b              (rst_b),
		.bus_req            (bus_req),
		.rd_data            (rd_data),
		.main_clk_tick      (main_clk_tick),
		.rc_osc_tick        (rc_osc_tick),
		.supply             (supply),
		.bus_clk_pulse      (bus_clk_pulse),
		.timer3_clk_en      (timer3_clk_en),
		.timer3_reset       (timer3_reset),
		.brownout_reset_req (brownout_reset_req),
		.brownout_irq       (brownout_irq),
		.wake_req           (wake_req),
		.irq                (irq)
	);

	always #50 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// Ticks are random so the switch handshake sees irregular source edges
	always @(posedge sys_clk) begin
		lfsr <= lfsr_next(lfsr);
		main_clk_tick <= tick_en & lfsr[0];
		rc_osc_tick <= tick_en & lfsr[7];
	end

	always @(posedge sys_clk) begin
		if (bus_clk_pulse === 1'b1)
			pulse_cnt++;
		if (timer3_clk_en === 1'b1)
			t3_cnt++;
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge sys_clk) begin
		if (rd_q) begin
			exp_v = exp_q.pop_front();
			`CHK("rd_data", exp_v, rd_data)
		end
		rd_q <= bus_req.rd;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out;
		$display("Checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Each access starts on an edge, so callers may come from a falling edge
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge sys_clk);
		bus_req <= '0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		exp_q.push_back(e);
		bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
		@(posedge sys_clk);
		bus_req <= '0;
	endtask

	task automatic mid(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask

	task automatic count(input int n);
		@(negedge sys_clk);
		pulse_cnt = 0;
		t3_cnt = 0;
		mid(n);
	endtask

	task automatic drive(input async_sysctl_pkg::supply_status_t s);
		@(posedge sys_clk);
		supply <= s;
	endtask

	task automatic wait_irq;
		int i;
		for (i = 0; i < 200 && irq !== 1'b1; i++)
			@(negedge sys_clk);
		if (irq !== 1'b1) begin
			fail_count++;
			$display("Error irq expected 1 seen %b", irq);
			close_out();
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		ra = '{12'h000, 12'h004, 12'h008, 12'h010, 12'h014, 12'h018,
			12'h020, 12'h030, 12'h044, 12'h050, 12'h054, 12'h0FC};
		rv = '{default: 32'h0000_0000};
		rv[7] = 32'h0000_0001;
		repeat (5) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge sys_clk);
		for (int i = 0; i < 12; i++)
			rd(ra[i], rv[i]);
		wr(12'h000, 32'hFFFF_DFFF);
		rd(12'h000, 32'h0000_0000);
		wr(12'h004, 32'h0000_2000);
		rd(12'h000, 32'h0000_2000);
		mid(2);
		`CHK("timer3_reset", 1'b1, timer3_reset)
		wr(12'h008, 32'h0000_0000);
		rd(12'h000, 32'h0000_2000);
		wr(12'h008, 32'h0000_2000);
		rd(12'h000, 32'h0000_0000);
		mid(2);
		`CHK("timer3_reset", 1'b0, timer3_reset)
		tick_en = 1'b1;
		wr(12'h014, 32'h0000_2000);
		rd(12'h010, 32'h0000_2000);
		wr(12'h018, 32'h0000_0000);
		rd(12'h014, 32'h0000_0000);
		count(40);
		`CHK("timer3_clk_en", 1'b1, t3_cnt != 0)
		wr(12'h018, 32'h0000_2000);
		rd(12'h010, 32'h0000_0000);
		count(40);
		`CHK("timer3_clk_en", 1'b1, t3_cnt == 0)
		wr(12'h030, 32'h0000_0000);
		rd(12'h030, 32'h0000_0000);
		count(40);
		`CHK("bus_clk_pulse", 1'b1, pulse_cnt == 0)
		wr(12'h030, 32'h0000_0001);
		wr(12'h054, 32'h0000_0001);
		foreach (codes[i]) begin
			if (i == 0)
				tick_en = 1'b0;
			wr(12'h020, {30'h0, codes[i]});
			if (i == 0) begin
				// Without source ticks the switch must not complete
				mid(20);
				`CHK("irq", 1'b0, irq)
				tick_en = 1'b1;
			end
			// A reserved code parks the clock and raises no done status
			if (codes[i] != 2'h2)
				wait_irq();
			else
				mid(20);
			rd(12'h020, {30'h0, codes[i]});
			rd(12'h050, {31'h0, codes[i] != 2'h2});
			wr(12'h050, 32'h0000_0001);
			mid(2);
			`CHK("irq", 1'b0, irq)
			count(40);
			`CHK("bus_clk_pulse", codes[i] != 2'h2, pulse_cnt != 0)
		end
		wr(12'h054, 32'h0000_0002);
		for (int l = 0; l < 4; l++) begin
			oh = 4'h1 << l;
			cfg = 32'(l) | 32'h0000_0024 | (32'(l) << 3);
			wr(12'h044, cfg);
			rd(12'h044, cfg);
			drive('{sleep: 1'b0, deep_sleep: 1'b0, below_rst_lvl: ~oh, below_irq_lvl: ~oh});
			mid(2);
			`CHK("brownout_reset_req", 1'b0, brownout_reset_req)
			`CHK("brownout_irq", 1'b0, brownout_irq)
			drive('{sleep: l == 1, deep_sleep: l == 2, below_rst_lvl: oh, below_irq_lvl: oh});
			mid(2);
			`CHK("brownout_reset_req", 1'b1, brownout_reset_req)
			`CHK("brownout_irq", 1'b1, brownout_irq)
			`CHK("wake_req", l == 1 || l == 2, wake_req)
			`CHK("irq", 1'b1, irq)
			drive('0);
			rd(12'h044, cfg | 32'h0000_00C0);
			wr(12'h044, cfg | 32'h0000_0080);
			rd(12'h044, cfg | 32'h0000_0040);
			wr(12'h044, cfg | 32'h0000_0040);
			rd(12'h044, cfg);
			wr(12'h050, 32'h0000_0002);
			mid(2);
			`CHK("irq", 1'b0, irq)
		end
		wr(12'h044, 32'h0000_001B);
		drive('{sleep: 1'b1, deep_sleep: 1'b0, below_rst_lvl: 4'hF, below_irq_lvl: 4'hF});
		mid(2);
		`CHK("brownout_reset_req", 1'b0, brownout_reset_req)
		`CHK("brownout_irq", 1'b0, brownout_irq)
		`CHK("wake_req", 1'b0, wake_req)
		rd(12'h044, 32'h0000_001B);
		mid(2);
		close_out();
	end
endmodule
